// file: bench/lsc_ctrl_chk.sv
// assertion checker for the lin control register block
`timescale 1ns/10ps
`include "lsc_consts.vh"
module lsc_ctrl_chk (
  input wire logic        clk_in,        // core clock
  input wire logic        rst_in,        // async reset
  input wire logic [1:0]  addr_in,       // register index
  input wire logic [15:0] wdata_in,      // write data
  input wire logic        wr_in,         // write strobe
  input wire logic        lin_rx_in,     // bus level
  input wire logic        brk_in,        // break pulse
  input wire logic        cks_sent_in,   // checksum sent
  input wire logic        enable_out,    // enabled
  input wire logic        tx_mode_out,   // transmit mode
  input wire logic        send_cks_out,  // send checksum
  input wire logic [7:0]  cks_out,       // checksum
  input wire logic        brk_again_out, // sync timed as break
  input wire logic        irq_out        // interrupt
);
  wire         wr0 = wr_in && addr_in == 2'h0;
  logic [11:0] low_cnt;
  // saturates so a stuck-low line never wraps back under the limit
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in) low_cnt <= 12'h000;
    else if (lin_rx_in) low_cnt <= 12'h000;
    else if (low_cnt != 12'hFFF) low_cnt <= low_cnt + 12'h001;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  en_follow_a: assert property (wr0 |=> enable_out == $past(wdata_in[11]))
    else $error("enable differs from written bit");
  cks_write_a: assert property (wr0 |=> send_cks_out == $past(wdata_in[8]))
    else $error("send checksum differs from written bit");
  cks_clear_a: assert property (cks_sent_in && enable_out
    && !(wr0 && wdata_in[8]) |=> !send_cks_out)
    else $error("send checksum not cleared");
  mode_clear_a: assert property (brk_in && enable_out
    && !(wr0 && wdata_in[0]) |=> !tx_mode_out)
    else $error("transmit mode not cleared by break");
  cks_idle_a: assert property (!enable_out ##1 !enable_out |-> cks_out == 8'hFF)
    else $error("checksum not held while disabled");
  irq_idle_a: assert property (!enable_out ##1 !enable_out |=> !irq_out)
    else $error("interrupt while disabled");
  sync_long_a: assert property ($rose(brk_again_out) |-> !$past(lin_rx_in)
    && low_cnt >= `LSC_SYNC_MAX_CLK)
    else $error("second break flagged too early");
  sync_end_a: assert property (lin_rx_in [*3] |-> !brk_again_out)
    else $error("second break held after line high");
endmodule // lsc_ctrl_chk
bind lsc_ctrl lsc_ctrl_chk chk_i (.clk_in, .rst_in, .addr_in, .wdata_in,
  .wr_in, .lin_rx_in, .brk_in, .cks_sent_in, .enable_out, .tx_mode_out,
  .send_cks_out, .cks_out, .brk_again_out, .irq_out);

// file: bench/lsc_master_model.sv
// lin master node model: bus level and break detection pulses
`timescale 1ns/10ps
module lsc_master_model (
  input  wire logic clk_in,     // core clock
  output logic      lin_rx_out, // bus level, recessive high
  output logic      brk_out     // valid break seen, pulse
);
  initial lin_rx_out = 1'b1;
  initial brk_out = 1'b0;
  task brk;
    @(posedge clk_in);
    brk_out <= 1'b1;
    @(posedge clk_in);
    brk_out <= 1'b0;
  endtask
  // caller returns to the pulled-up level itself when done
  task line(input logic v, input int n);
    lin_rx_out <= v;
    repeat (n) @(posedge clk_in);
  endtask
  task edges(input int n);
    repeat (n) begin
      line(1'b0, 1);
      line(1'b1, 1);
    end
  endtask
endmodule // lsc_master_model

// file: bench/testbench.sv
// self-checking bench for the lin control register block
`timescale 1ns/10ps
module testbench;
  logic        clk_in = 1'b0, rst_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0;
  logic [1:0]  addr_in = 2'h0;
  logic [15:0] wdata_in = 16'h0000, rdata_out;
  logic        tx_ready_in = 1'b0, col_in = 1'b0, tx_done_in = 1'b0;
  logic        byte_in = 1'b0, byte_pid_in = 1'b0, cks_sent_in = 1'b0;
  logic [7:0]  byte_val_in = 8'h00, cks_out;
  logic        lin_rx_in, brk_in, enable_out, tx_mode_out, send_cks_out;
  logic        brk_again_out, irq_out;
  int          err_count = 0, num_checks = 0;
  always #5 clk_in = ~clk_in;
  lsc_master_model m (.clk_in, .lin_rx_out(lin_rx_in), .brk_out(brk_in));
  lsc_ctrl dut (.clk_in, .rst_in, .addr_in, .wdata_in, .wr_in, .rd_in,
    .rdata_out, .lin_rx_in, .brk_in, .col_in, .tx_ready_in, .tx_done_in,
    .byte_in, .byte_val_in, .byte_pid_in, .cks_sent_in, .enable_out,
    .tx_mode_out, .send_cks_out, .cks_out, .brk_again_out, .irq_out);
  task chk(input string n, input logic [15:0] s, e);
    num_checks++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task rd(input logic [1:0] a, input logic [15:0] e);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 chk($sformatf("reg %0d", a), rdata_out, e);
  endtask
  // pulse: bit 2 checksum sent, bit 1 transmit done, bit 0 collision
  task pl(input logic [2:0] w);
    @(posedge clk_in);
    {cks_sent_in, tx_done_in, col_in} <= w;
    @(posedge clk_in);
    {cks_sent_in, tx_done_in, col_in} <= 3'h0;
  endtask
  task bt(input logic [7:0] v, input logic p);
    @(posedge clk_in);
    byte_in <= 1'b1;
    byte_val_in <= v;
    byte_pid_in <= p;
    @(posedge clk_in);
    byte_in <= 1'b0;
  endtask
  task ik(input logic e);
    repeat (3) @(posedge clk_in);
    #1 chk("irq", irq_out, e);
  endtask
  task t_rst;
    rd(2'h0, 16'h0000);
    rd(2'h2, 16'h00FF);
    wr(2'h3, 16'hFFFF);
    rd(2'h3, 16'h0000);
    wr(2'h0, 16'hFFFF);
    rd(2'h0, 16'h1FFF);
    chk("enable", enable_out, 1'b1);
    $display("done reset and map");
  endtask
  task t_send;
    wr(2'h0, 16'h0800);
    tx_ready_in <= 1'b1;
    ik(1'b1);
    wr(2'h0, 16'h0901);
    ik(1'b0);
    rd(2'h0, 16'h0903);
    chk("send_cks", send_cks_out, 1'b1);
    chk("tx_mode", tx_mode_out, 1'b1);
    pl(3'h4);
    rd(2'h0, 16'h0803);
    chk("send_cks", send_cks_out, 1'b0);
    m.brk();
    rd(2'h0, 16'h0802);
    chk("tx_mode", tx_mode_out, 1'b0);
    tx_ready_in <= 1'b0;
    $display("done send checksum");
  endtask
  task t_cks;
    wr(2'h0, 16'h0800);
    m.brk();
    bt(8'h3C, 1'b1);
    bt(8'h10, 1'b0);
    rd(2'h2, 16'h00B3);
    chk("cks_out", cks_out, 8'hB3);
    wr(2'h0, 16'h0880);
    rd(2'h2, 16'h00FF);
    chk("cks_out", cks_out, 8'hFF);
    bt(8'h3C, 1'b1);
    bt(8'h10, 1'b0);
    rd(2'h2, 16'h00EF);
    chk("cks_out", cks_out, 8'hEF);
    $display("done checksum");
  endtask
  task t_col;
    wr(2'h0, 16'h0848);
    m.brk();
    rd(2'h1, 16'h0008);
    pl(3'h2);
    pl(3'h1);
    ik(1'b0);
    rd(2'h1, 16'h0004);
    rd(2'h1, 16'h0004);
    m.brk();
    rd(2'h1, 16'h0008);
    pl(3'h1);
    ik(1'b1);
    rd(2'h1, 16'h0010);
    wr(2'h0, 16'h0810);
    pl(3'h2);
    pl(3'h1);
    ik(1'b1);
    rd(2'h1, 16'h0014);
    wr(2'h0, 16'h0814);
    ik(1'b0);
    m.brk();
    ik(1'b1);
    rd(2'h1, 16'h0008);
    pl(3'h1);
    ik(1'b0);
    rd(2'h1, 16'h0010);
    $display("done collision");
  endtask
  task t_neg;
    wr(2'h0, 16'h085E);
    m.brk();
    m.edges(57);
    rd(2'h1, 16'h0008);
    m.edges(1);
    ik(1'b1);
    rd(2'h1, 16'h0020);
    $display("done edge count");
  endtask
  task t_sync;
    wr(2'h0, 16'h0A00);
    m.brk();
    m.line(1'b1, 4);
    m.line(1'b0, 760);
    #1 chk("brk_again", brk_again_out, 1'b1);
    m.line(1'b1, 4);
    #1 chk("brk_again", brk_again_out, 1'b0);
    wr(2'h0, 16'h0800);
    m.brk();
    m.line(1'b1, 4);
    m.line(1'b0, 760);
    #1 chk("brk_again", brk_again_out, 1'b0);
    m.line(1'b1, 4);
    $display("done sync timing");
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    t_rst;
    t_send;
    t_cks;
    t_col;
    t_neg;
    t_sync;
    complete_run;
  end
  // the whole run needs about 1800 cycles
  initial begin
    repeat (20000) @(posedge clk_in);
    err_count++;
    complete_run;
  end
endmodule // testbench

// file: verilog/lsc_consts.vh
// register map, field positions, reset values and counts of the lin control
`ifndef LSC_CONSTS_VH
`define LSC_CONSTS_VH

`define LSC_ADDR_W          2
`define LSC_A_CTRL          2'h0
`define LSC_A_FLAGS         2'h1
`define LSC_A_CKS           2'h2

`define LSC_CTRL_WMASK      16'h1FFF
`define LSC_CTRL_RST        16'h0000
`define LSC_FLAGS_RST       5'h00
`define LSC_CKS_RST         8'hFF

`define LSC_B_TXMODE        0
`define LSC_B_M_TXRDY       1
`define LSC_B_M_TXC         2
`define LSC_B_M_BRK         3
`define LSC_B_M_COL         4
`define LSC_B_M_NEG         5
`define LSC_B_M_COLTXC      6
`define LSC_B_CLASSIC       7
`define LSC_B_SENDCKS       8
`define LSC_B_SYNCCHK       9
`define LSC_B_EN            11

`define LSC_F_TXRDY         1
`define LSC_F_TXC           2
`define LSC_F_BRK           3
`define LSC_F_COL           4
`define LSC_F_NEG           5

`define LSC_SYNC_MAX_CLK    750
`define LSC_SYNC_CNT_W      12
`define LSC_NEG_MAX         57
`define LSC_NEG_CNT_W       7

`endif

// file: verilog/lsc_ctrl.v
// lin slave control register, event flags, checksum and frame checks
//
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
`include "lsc_consts.vh"
module lsc_ctrl (
  input  wire                   clk_in,       // core clock, 100 MHz
  input  wire                   rst_in,       // async reset, active high
  input  wire [`LSC_ADDR_W-1:0] addr_in,      // register index
  input  wire [15:0]            wdata_in,     // write data
  input  wire                   wr_in,        // write strobe
  input  wire                   rd_in,        // read strobe
  output reg  [15:0]            rdata_out,    // read data, cycle after rd
  input  wire                   lin_rx_in,    // received bus level
  input  wire                   brk_in,       // valid break seen, pulse
  input  wire                   col_in,       // collision seen, pulse
  input  wire                   tx_ready_in,  // byte moved to shifter
  input  wire                   tx_done_in,   // all data sent, pulse
  input  wire                   byte_in,      // byte moved on bus, pulse
  input  wire [7:0]             byte_val_in,  // value of that byte
  input  wire                   byte_pid_in,  // that byte is the pid
  input  wire                   cks_sent_in,  // checksum byte sent, pulse
  output reg                    enable_out,   // interface enabled
  output reg                    tx_mode_out,  // transmit data bytes
  output reg                    send_cks_out, // append checksum now
  output reg  [7:0]             cks_out,      // checksum byte to send
  output reg                    brk_again_out,// sync low timed as break
  output reg                    irq_out       // interrupt request
);

  reg  [15:0] lin_control;
  reg  [5:1]  lin_event_flags;
  reg  [7:0]  running_checksum;
  reg  [15:0] next_control;
  reg  [5:1]  next_flags;
  reg  [7:0]  next_cks;
  reg  [15:0] next_rdata;
  reg  [8:0]  cks_sum;
  reg         rx_q;
  reg         sync_arm;
  reg         neg_over_q;
  reg         next_irq;
  reg         next_sync_arm;
  reg         next_brk_again;

  wire                         en;
  wire                         fall;
  wire                         rise;
  wire                         col_ok;
  wire                         flags_rd;
  wire                         ctl_wr;
  wire                         class_chg;
  wire [`LSC_SYNC_CNT_W-1:0]   low_cnt;
  wire                         low_over;
  wire [`LSC_NEG_CNT_W-1:0]    neg_cnt;
  wire                         neg_over;

  assign en       = lin_control[`LSC_B_EN];
  assign fall     = rx_q & ~lin_rx_in;
  assign rise     = ~rx_q & lin_rx_in;
  assign flags_rd = rd_in && (addr_in == `LSC_A_FLAGS);
  assign ctl_wr   = wr_in && (addr_in == `LSC_A_CTRL);
  // late collisions are dropped only while the combined mask is set;
  // one that lands before transmit complete still counts
  assign col_ok   = ~lin_control[`LSC_B_M_COLTXC]
                  | ~lin_event_flags[`LSC_F_TXC];
  assign class_chg = ctl_wr && en &&
                     (wdata_in[`LSC_B_CLASSIC] !=
                      lin_control[`LSC_B_CLASSIC]);

  // low time of the sync start bit, counted only when the check is on
  lsc_sat_cnt #(
    .W     (`LSC_SYNC_CNT_W),
    .LIMIT (`LSC_SYNC_MAX_CLK)
  ) u_low (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .clr_in    (~en | lin_rx_in | ~sync_arm),
    .inc_in    (lin_control[`LSC_B_SYNCCHK]),
    .count_out (low_cnt),
    .over_out  (low_over)
  );

  // falling edges since the last break
  lsc_sat_cnt #(
    .W     (`LSC_NEG_CNT_W),
    .LIMIT (`LSC_NEG_MAX)
  ) u_neg (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .clr_in    (~en | brk_in),
    .inc_in    (fall),
    .count_out (neg_cnt),
    .over_out  (neg_over)
  );

  // control register
  always @* begin
    next_control = lin_control;
    if (ctl_wr) begin
      next_control = wdata_in & `LSC_CTRL_WMASK;
    end
    if (en && cks_sent_in) begin
      next_control[`LSC_B_SENDCKS] = 1'b0;
    end
    if (en && brk_in) begin
      next_control[`LSC_B_TXMODE] = 1'b0;
    end
    // a software write in the same cycle wins over the hardware clears
    if (ctl_wr) begin
      if (wdata_in[`LSC_B_SENDCKS]) begin
        next_control[`LSC_B_SENDCKS] = 1'b1;
        next_control[`LSC_B_M_TXRDY] = 1'b1;
      end
      if (wdata_in[`LSC_B_TXMODE]) begin
        next_control[`LSC_B_TXMODE] = 1'b1;
      end
    end
  end

  // event flags; every hardware set wins over the read clear
  always @* begin
    next_flags = lin_event_flags;
    if (!en) begin
      next_flags = `LSC_FLAGS_RST;
    end else begin
      if (flags_rd) begin
        next_flags[`LSC_F_COL] = 1'b0;
        next_flags[`LSC_F_BRK] = 1'b0;
        next_flags[`LSC_F_NEG] = 1'b0;
      end
      // transmit ready mirrors the shifter handshake, one cycle late
      next_flags[`LSC_F_TXRDY] = tx_ready_in;
      if (brk_in) begin
        next_flags[`LSC_F_TXC] = 1'b0;
        next_flags[`LSC_F_BRK] = 1'b1;
      end
      if (tx_done_in) begin
        next_flags[`LSC_F_TXC] = 1'b1;
      end
      if (col_in && col_ok) begin
        next_flags[`LSC_F_COL] = 1'b1;
      end
      if (neg_over && !neg_over_q) begin
        next_flags[`LSC_F_NEG] = 1'b1;
      end
    end
  end

  // running checksum, held inverted so it reads straight out
  always @* begin
    cks_sum  = {1'b0, ~running_checksum} + {1'b0, byte_val_in};
    next_cks = running_checksum;
    if (!en || brk_in || class_chg) begin
      next_cks = `LSC_CKS_RST;
    end else if (byte_in &&
                 !(byte_pid_in &&
                   lin_control[`LSC_B_CLASSIC])) begin
      next_cks = ~(cks_sum[7:0] + {7'h00, cks_sum[8]});
    end
  end

  // read mux; unmapped indices read zero
  always @* begin
    next_rdata = 16'h0000;
    case (addr_in)
      `LSC_A_CTRL: begin
        next_rdata = lin_control;
      end
      `LSC_A_FLAGS: begin
        // bit 0 of the flag word is unused and reads zero
        next_rdata = {10'h000, lin_event_flags, 1'b0};
      end
      `LSC_A_CKS: begin
        next_rdata = {8'h00, running_checksum};
      end
      default: begin
        next_rdata = 16'h0000;
      end
    endcase
  end

  // one pending unmasked flag raises the request
  always @* begin
    next_irq = 1'b0;
    if (lin_event_flags[`LSC_F_COL] &&
        !lin_control[`LSC_B_M_COL]) begin
      next_irq = 1'b1;
    end
    // the combined mask silences transmit complete as well
    if (lin_event_flags[`LSC_F_TXC] &&
        !lin_control[`LSC_B_M_TXC] &&
        !lin_control[`LSC_B_M_COLTXC]) begin
      next_irq = 1'b1;
    end
    if (lin_event_flags[`LSC_F_BRK] &&
        !lin_control[`LSC_B_M_BRK]) begin
      next_irq = 1'b1;
    end
    if (lin_event_flags[`LSC_F_NEG] &&
        !lin_control[`LSC_B_M_NEG]) begin
      next_irq = 1'b1;
    end
    if (lin_event_flags[`LSC_F_TXRDY] &&
        !lin_control[`LSC_B_M_TXRDY]) begin
      next_irq = 1'b1;
    end
  end

  // sync start bit: a break arms the timer; the first rising edge after
  // a counted low ends the start bit and disarms unless it ran too long
  always @* begin
    next_sync_arm = sync_arm;
    if (!en) begin
      next_sync_arm = 1'b0;
    end else if (brk_in) begin
      next_sync_arm = 1'b1;
    end else if (rise && low_cnt != {`LSC_SYNC_CNT_W{1'b0}}) begin
      next_sync_arm = low_over;
    end
    // held while the line stays low so the break timer keeps going
    next_brk_again = en && sync_arm && low_over && ~lin_rx_in;
  end

  // register state
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      lin_control      <= `LSC_CTRL_RST;
      lin_event_flags  <= `LSC_FLAGS_RST;
      running_checksum <= `LSC_CKS_RST;
      rx_q             <= 1'b1;  // idle level, no false fall after reset
      neg_over_q       <= 1'b0;
    end else begin
      lin_control      <= next_control;
      lin_event_flags  <= next_flags;
      running_checksum <= next_cks;
      rx_q             <= lin_rx_in;
      neg_over_q       <= neg_over;
    end
  end

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync_arm      <= 1'b0;
      brk_again_out <= 1'b0;
    end else begin
      sync_arm      <= next_sync_arm;
      brk_again_out <= next_brk_again;
    end
  end

  // read data stands one cycle after the strobe, zero otherwise
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out <= 16'h0000;
    end else begin
      rdata_out <= rd_in ? next_rdata : 16'h0000;
    end
  end

  // outputs but irq_out load from the same next values, so each mirrors its
  // register on the edge that updates it; irq_out follows the flags a cycle late
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      enable_out   <= 1'b0;
      tx_mode_out  <= 1'b0;
      send_cks_out <= 1'b0;
      cks_out      <= `LSC_CKS_RST;
      irq_out      <= 1'b0;
    end else begin
      enable_out   <= next_control[`LSC_B_EN];
      tx_mode_out  <= next_control[`LSC_B_TXMODE];
      send_cks_out <= next_control[`LSC_B_SENDCKS];
      cks_out      <= next_cks;
      irq_out      <= next_irq;
    end
  end

endmodule // lsc_ctrl

// file: verilog/lsc_sat_cnt.v
// saturating up counter with clear and an over-limit level
`timescale 1ns/10ps
module lsc_sat_cnt #(
  parameter W     = 8,
  parameter LIMIT = 8
) (
  input  wire         clk_in,    // core clock
  input  wire         rst_in,    // async reset, active high
  input  wire         clr_in,    // clear count, wins over inc
  input  wire         inc_in,    // count one step
  output reg  [W-1:0] count_out, // current count
  output wire         over_out   // count above limit
);

  localparam [W-1:0] LIM = LIMIT[W-1:0];
  localparam [W-1:0] TOP = {W{1'b1}};

  // saturate so a very long low never wraps back under the limit
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      count_out <= {W{1'b0}};
    end else if (clr_in) begin
      count_out <= {W{1'b0}};
    end else if (inc_in && count_out != TOP) begin
      count_out <= count_out + {{(W-1){1'b0}}, 1'b1};
    end
  end

  assign over_out = (count_out > LIM);

endmodule // lsc_sat_cnt
